// *** src/rcs_seq.sv ***
/*
  rcs_seq: reset sequencer, cause recording, clock gating and bus divide.
  assumes: ref_clk is the oscillator reference; pll tick and pins are
  asynchronous and synchronised here; cpu decode inputs share ref_clk.
*/
`timescale 1ns/100ps
// Functional notes
// - bus tick is source clock divided by four
// - por/undervolt hold clocks 4096, pin low
// - stop exit waits stop delay, clocks off
// - wait mode stops cpu clock only
// - every reset asserts internal reset, vector
// - internal reset clears counter, pin does not
// - each source sets its own cause flag
// - pin low halts; long low sets flag
// - internal reset drives pin 32, then 32
// - por/undervolt hold 4096 before normal sequence
// - recovery 4160 long, 64 internal, 32 after pin release
// - watchdog request taken without bus clock
// - power on: 4096 hold, release 64 later
// - power on clears all other flags
// - watchdog overflow resets unless disabled
// - illegal opcode sets flag and resets
// - stop without allow is illegal opcode
// - only opcode fetch from unmapped resets
// - undervolt resets when both disables zero
// - undervolt holds 4096 after recovery
// - cause flag bit positions fixed
// - break control bit7, break wait bit1
// - 12-bit system counter on reference clock
// - short recovery bit picks 32 or 4096
// - break clear enable gates flag clearing
module rcs_seq
  import rcs_pkg::*;
#(
  parameter int unsigned LONG_HOLD = POR_HOLD_CYC,
  parameter int unsigned STOP_LONG = STOP_LONG_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              power_on_pulse,
  input  wire logic              undervolt_det,
  input  wire logic              rst_pin_i,
  output logic                   rst_pin_o,
  output logic                   rst_pin_oe,
  input  wire logic              watchdog_ovf,
  input  wire logic              cpu_bad_opcode,
  input  wire logic              cpu_stop_exec,
  input  wire logic              cpu_opcode_fetch,
  input  wire logic              addr_unmapped,
  input  wire logic              stop_req,
  input  wire logic              wait_req,
  input  wire logic              wake_req,
  input  wire logic              break_active,
  input  wire logic              monitor_mode,
  input  wire logic              pll_sel,
  input  wire logic              pll_out_clock,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   internal_reset,
  output logic                   cpu_clk_en,
  output logic                   periph_clk_en,
  output logic                   bus_tick,
  output logic      [15:0]       reset_vector,
  output logic                   flag_clear_ok,
  output logic      [SYSCNT_W-1:0] sys_count
);
  // ==========================================================
  // state
  typedef struct packed {
    rcs_state_t          st;
    logic [12:0]         cnt;
    logic [SYSCNT_W-1:0] syscnt;
    logic [7:0]          cause;
    logic [7:0]          cfg;
    logic                break_clear_enable;
    logic                bwait;
    logic                stopped;
    logic                waiting;
    logic [7:0]          pin_low;
    logic [7:0]          rdata;
    logic                pll_d;
    logic                wd_q;
  } rcs_top_t;
  rcs_top_t s_q;
  rcs_top_t s_d;
  logic [3:0] async_s;
  logic       pin_s;
  logic       uv_s;
  logic       pll_s;
  logic       wd_s;
  logic       pll_tick;
  logic       src_tick;
  logic       int_src;
  logic [7:0] int_cause;
  logic       long_src;
  logic [12:0] stop_len;
  // ==========================================================
  // synchronisers: pins and the pll clock sampled twice
  rcs_sync #(
    .W(4)
  ) u_sync (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .async_in  ({rst_pin_i, undervolt_det, pll_out_clock, watchdog_ovf}),
    .reset_val (4'h8),
    .sync_out  (async_s)
  );
  assign pin_s = async_s[3];
  assign uv_s  = async_s[2];
  assign pll_s = async_s[1];
  // watchdog is taken on the reference clock, not the bus tick
  assign wd_s  = async_s[0];
  assign pll_tick = pll_s & ~s_q.pll_d;
  assign src_tick = pll_sel ? pll_tick : 1'b1;
  rcs_clkdiv #(
    .DIV(BUS_DIV)
  ) u_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .src_tick (src_tick),
    .run      (cpu_clk_en | periph_clk_en),
    .bus_tick (bus_tick)
  );
  // ==========================================================
  // reset source decode
  always_comb
  begin
    int_cause = 8'h00;
    int_cause[RC_POR_BIT]      = power_on_pulse;
    int_cause[RC_WDOG_BIT]     = wd_s & ~s_q.cfg[CFG_WDOG_DIS_BIT];
    int_cause[RC_BADOP_BIT]    = cpu_bad_opcode
      | (cpu_stop_exec & ~s_q.cfg[CFG_STOP_OK_BIT]);
    int_cause[RC_BADFETCH_BIT] = cpu_opcode_fetch & addr_unmapped;
    int_cause[RC_UVOLT_BIT]    = uv_s & ~s_q.cfg[CFG_UV_PWRD_BIT]
      & ~s_q.cfg[CFG_UV_RSTD_BIT];
  end
  assign int_src  = |int_cause;
  assign long_src = int_cause[RC_POR_BIT] | int_cause[RC_UVOLT_BIT];
  assign stop_len = s_q.cfg[CFG_SHORT_STOP_RECOVERY_BIT] ? 13'(STOP_SHORT_CYC)
                                           : 13'(STOP_LONG);
  // ==========================================================
  // sequencer
  always_comb
  begin
    s_d        = s_q;
    s_d.pll_d  = pll_s;
    s_d.wd_q   = wd_s;
    s_d.syscnt = s_q.syscnt + 1'b1;
    s_d.rdata  = 8'h00;
    s_d.pin_low = (pin_s || s_q.st != RCS_RUN) ? 8'h00
      : (s_q.pin_low == 8'hff ? 8'hff : s_q.pin_low + 8'h01);
    if (int_src)
    begin
      s_d.syscnt = '0;
      s_d.cnt    = '0;
      s_d.st     = long_src ? RCS_LONG_HOLD : RCS_PIN_DRIVE;
      s_d.cause  = s_q.cause | int_cause;
      if (int_cause[RC_POR_BIT])
      begin
        s_d.cause = 8'h00;
        s_d.cause[RC_POR_BIT] = 1'b1;
        s_d.cfg = CFG_RESET;
      end
      s_d.stopped = 1'b0;
      s_d.waiting = 1'b0;
    end
    else
    begin
      case (s_q.st)
        RCS_RUN:
        begin
          if (!pin_s)
          begin
            s_d.st = RCS_EXT_HOLD;
            s_d.cnt = '0;
          end
          else if (s_q.stopped && wake_req)
          begin
            s_d.st  = RCS_STOP_WAKE;
            s_d.cnt = '0;
          end
          else if (stop_req)
          begin
            s_d.stopped = 1'b1;
            s_d.syscnt  = '0;
          end
          else if (wait_req)
          begin
            s_d.waiting = 1'b1;
          end
          else if (wake_req)
          begin
            s_d.waiting = 1'b0;
          end
        end
        RCS_LONG_HOLD:
        begin
          // counting restarts while undervolt persists
          if (uv_s && int_cause[RC_UVOLT_BIT])
            s_d.cnt = '0;
          else if (s_q.cnt == 13'(LONG_HOLD - 1))
          begin
            s_d.st  = RCS_PIN_DRIVE;
            s_d.cnt = '0;
          end
          else
            s_d.cnt = s_q.cnt + 13'h0001;
        end
        RCS_PIN_DRIVE:
        begin
          if (s_q.cnt == 13'(PIN_DRIVE_CYC - 1))
          begin
            s_d.st  = RCS_INTERNAL_RESET_TAIL;
            s_d.cnt = '0;
          end
          else
            s_d.cnt = s_q.cnt + 13'h0001;
        end
        RCS_INTERNAL_RESET_TAIL:
        begin
          if (s_q.cnt == 13'(INTERNAL_RESET_EXTRA_CYC - 1))
          begin
            s_d.st  = RCS_RUN;
            s_d.cnt = '0;
          end
          else
            s_d.cnt = s_q.cnt + 13'h0001;
        end
        RCS_EXT_HOLD:
        begin
          // external reset leaves the system counter running
          if (pin_s)
          begin
            s_d.st  = RCS_INTERNAL_RESET_TAIL;
            s_d.cnt = '0;
          end
          if (!pin_s && s_q.pin_low == 8'(PIN_MIN_LOW_CYC - 1))
            s_d.cause[RC_PIN_BIT] = 1'b1;
        end
        RCS_STOP_WAKE:
        begin
          if (s_q.cnt == stop_len - 13'h0001)
          begin
            s_d.st      = RCS_RUN;
            s_d.stopped = 1'b0;
          end
          else
            s_d.cnt = s_q.cnt + 13'h0001;
        end
        default: s_d.st = RCS_RUN;
      endcase
    end
    if (s_q.st == RCS_EXT_HOLD && !pin_s && s_q.pin_low != 8'hff)
      s_d.pin_low = s_q.pin_low + 8'h01;
    if (s_q.st == RCS_EXT_HOLD && !pin_s
        && s_q.pin_low >= 8'(PIN_MIN_LOW_CYC - 1))
      s_d.cause[RC_PIN_BIT] = 1'b1;
    // registers: cause is read only, writes dropped
    if (reg_wr && !int_src && s_q.st == RCS_RUN)
    begin
      if (reg_addr == ADDR_BREAK_FLAG)
        s_d.break_clear_enable = reg_wdata[BREAK_CLEAR_ENABLE_BIT];
      else if (reg_addr == ADDR_BREAK_STATUS)
        s_d.bwait = s_q.bwait & reg_wdata[BWAIT_BIT];
      else if (reg_addr == ADDR_CONFIG)
        s_d.cfg = reg_wdata;
    end
    if (break_active && s_q.waiting)
      s_d.bwait = 1'b1;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_BREAK_STATUS: s_d.rdata = {6'h00, s_q.bwait, 1'b0};
        ADDR_RESET_CAUSE:  s_d.rdata = s_q.cause & 8'hfa;
        ADDR_BREAK_FLAG:   s_d.rdata = {s_q.break_clear_enable, 7'h00};
        ADDR_CONFIG:       s_d.rdata = s_q.cfg;
        default:           s_d.rdata = 8'h00;
      endcase
    end
    if (s_d.st != RCS_RUN)
      s_d.break_clear_enable = (int_src || s_q.st == RCS_EXT_HOLD) ? 1'b0 : s_d.break_clear_enable;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_q       <= '0;
      s_q.st    <= RCS_LONG_HOLD;
      s_q.cause <= 8'h80;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  // ==========================================================
  // outputs
  assign internal_reset = (s_q.st != RCS_RUN && s_q.st != RCS_STOP_WAKE);
  assign rst_pin_o      = 1'b0;
  assign rst_pin_oe     = (s_q.st == RCS_LONG_HOLD) || (s_q.st == RCS_PIN_DRIVE);
  assign cpu_clk_en     = !internal_reset && !s_q.stopped && !s_q.waiting
                          && s_q.st == RCS_RUN;
  assign periph_clk_en  = !internal_reset && !s_q.stopped && s_q.st == RCS_RUN;
  assign reset_vector   = monitor_mode ? VEC_MONITOR : VEC_USER;
  assign flag_clear_ok  = s_q.break_clear_enable | ~break_active;
  assign reg_rdata      = s_q.rdata;
  assign sys_count      = s_q.syscnt;
  // ==========================================================
  // checks
  pin_drive_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(s_q.st == RCS_PIN_DRIVE) |-> rst_pin_oe [*8])
    else $error("pin drive too short");
  tail_no_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.st == RCS_INTERNAL_RESET_TAIL |-> !rst_pin_oe && internal_reset)
    else $error("tail state drives pin");
  wdog_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wd_s && !s_q.cfg[CFG_WDOG_DIS_BIT] |=> s_q.cause[RC_WDOG_BIT])
    else $error("watchdog flag missing");
  por_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    power_on_pulse |=> s_q.cause == 8'h80)
    else $error("power on flags wrong");
  cause_ro_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && !int_src && s_q.st != RCS_EXT_HOLD |=> s_q.cause == $past(s_q.cause))
    else $error("cause changed by write");
  bad_fetch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    addr_unmapped && !cpu_opcode_fetch && !int_src && s_q.st == RCS_RUN
    |=> s_q.cause[RC_BADFETCH_BIT] == $past(s_q.cause[RC_BADFETCH_BIT]))
    else $error("data fetch caused reset");
  stop_illegal_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_stop_exec && !s_q.cfg[CFG_STOP_OK_BIT] |=> s_q.st == RCS_PIN_DRIVE)
    else $error("stop not illegal");
  wait_cpu_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.waiting && s_q.st == RCS_RUN && !s_q.stopped |-> !cpu_clk_en && periph_clk_en)
    else $error("wait gating wrong");
endmodule // rcs_seq

// *** src/rcs_pkg.sv ***
/*
  rcs_pkg: constants shared by the reset and clock sequencer.
  assumes: one reference clock domain, plain register port.
*/
package rcs_pkg;
  localparam int unsigned REF_CLK_MHZ       = 100;
  localparam int unsigned POR_HOLD_CYC      = 4096;
  localparam int unsigned PIN_DRIVE_CYC     = 32;
  localparam int unsigned INTERNAL_RESET_EXTRA_CYC    = 32;
  localparam int unsigned STOP_LONG_CYC     = 4096;
  localparam int unsigned STOP_SHORT_CYC    = 32;
  localparam int unsigned PIN_MIN_LOW_NS    = 100;
  localparam int unsigned PIN_MIN_LOW_CYC   =
    (PIN_MIN_LOW_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned SYSCNT_W          = 12;
  localparam int unsigned BUS_DIV           = 4;
  localparam logic [15:0] ADDR_BREAK_STATUS = 16'hfe00;
  localparam logic [15:0] ADDR_RESET_CAUSE  = 16'hfe01;
  localparam logic [15:0] ADDR_BREAK_FLAG   = 16'hfe03;
  localparam logic [15:0] ADDR_CONFIG       = 16'hfe04;
  localparam int unsigned RC_POR_BIT        = 7;
  localparam int unsigned RC_PIN_BIT        = 6;
  localparam int unsigned RC_WDOG_BIT       = 5;
  localparam int unsigned RC_BADOP_BIT      = 4;
  localparam int unsigned RC_BADFETCH_BIT   = 3;
  localparam int unsigned RC_UVOLT_BIT      = 1;
  localparam int unsigned BREAK_CLEAR_ENABLE_BIT          = 7;
  localparam int unsigned BWAIT_BIT         = 1;
  localparam int unsigned CFG_WDOG_DIS_BIT  = 0;
  localparam int unsigned CFG_UV_PWRD_BIT   = 1;
  localparam int unsigned CFG_UV_RSTD_BIT   = 2;
  localparam int unsigned CFG_SHORT_STOP_RECOVERY_BIT     = 3;
  localparam int unsigned CFG_STOP_OK_BIT   = 4;
  localparam logic [15:0] VEC_USER          = 16'hfffe;
  localparam logic [15:0] VEC_MONITOR       = 16'hfefe;
  localparam logic [7:0]  CFG_RESET         = 8'h00;
  typedef enum logic [2:0] {
    RCS_RUN, RCS_LONG_HOLD, RCS_PIN_DRIVE, RCS_INTERNAL_RESET_TAIL, RCS_EXT_HOLD, RCS_STOP_WAKE
  } rcs_state_t;
endpackage

// *** src/rcs_sync.sv ***
/*
  rcs_sync: two flip-flop level synchroniser.
  assumes: input comes from outside the ref_clk domain.
*/
`timescale 1ns/100ps
module rcs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] reset_val,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rcs_sync_t;
  rcs_sync_t st_q;
  rcs_sync_t st_d;
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end
  // reset value is a port constant; first stage is read by second only
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      // reset to the pin's idle level so no false edge follows reset
      st_q <= {reset_val, reset_val};
    end
    else
    begin
      st_q <= st_d;
    end
  end
  assign sync_out = st_q.s2;
endmodule // rcs_sync

// *** src/rcs_clkdiv.sv ***
/*
  rcs_clkdiv: bus clock enable generator, divide of the source clock.
  assumes: source select is static or changes only while gated.
*/
`timescale 1ns/100ps
module rcs_clkdiv
  import rcs_pkg::*;
#(
  parameter int unsigned DIV = BUS_DIV
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic src_tick,
  input  wire logic run,
  output logic      bus_tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } rcs_div_t;
  rcs_div_t st_q;
  rcs_div_t st_d;
  always_comb
  begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (!run)
    begin
      st_d.cnt = '0;
    end
    else if (src_tick)
    begin
      if (st_q.cnt == 8'(DIV - 1))
      begin
        st_d.cnt  = '0;
        st_d.tick = 1'b1;
      end
      else
      begin
        st_d.cnt = st_q.cnt + 8'h01;
      end
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
  assign bus_tick = st_q.tick;
endmodule // rcs_clkdiv

// *** tb/rcs_pin_model.sv ***
/*
  rcs_pin_model: far side of the reset pin, an external device on a pulled-up line.
  assumes: the sequencer only ever drives the pin low, oe high while it does.
*/
`timescale 1ns/100ps
// ==========================================
// reset pin wire
module rcs_pin_model (
  input  wire logic rst_pin_o,
  input  wire logic rst_pin_oe,
  input  wire logic pull_low,
  output logic      rst_pin_i
);
  // pull-up: a released pin reads high, so a stale level never hides a release
  assign rst_pin_i = !(pull_low || (rst_pin_oe && !rst_pin_o));
endmodule // rcs_pin_model

// *** tb/tb_rcs_seq.sv ***
/*
  tb_rcs_seq: self-checking bench for the reset and clock sequencer.
  assumes: rcs_pkg, rcs_seq and rcs_pin_model compiled before it.
*/
`timescale 1ns/100ps
module tb_rcs_seq;
  import rcs_pkg::*;
  // short long-hold and stop counts keep the run brief
  localparam int unsigned LH = 64;
  localparam int unsigned SL = 64;
  // ==========================================
  // signals
  logic                ref_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                pull_low = 1'b0;
  logic                break_active = 1'b0;
  logic                monitor_mode = 1'b0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  // ev: 0 wdog 1 badop 2 stopx 3 fetch 4 unmapped 5 stop 6 wait 7 wake 8 undervolt
  logic [8:0]          ev = 9'h000;
  logic [15:0]         reg_addr = 16'h0000;
  logic [7:0]          reg_wdata = 8'h00;
  logic                rst_pin_i, rst_pin_o, rst_pin_oe, internal_reset;
  logic                cpu_clk_en, periph_clk_en, bus_tick, flag_clear_ok;
  logic [1:0]          ck;
  logic [7:0]          reg_rdata, v;
  logic [15:0]         reset_vector, vec;
  logic [SYSCNT_W-1:0] sys_count, sc0;
  int                  err_count = 0;
  int                  check_count = 0;
  int                  cyc = 0;
  int                  p, t, n, c0;
  logic [8:0]          rmsk [5] = '{9'h001, 9'h002, 9'h004, 9'h018, 9'h100};
  int                  rbit [5] = '{RC_WDOG_BIT, RC_BADOP_BIT, RC_BADOP_BIT,
                                    RC_BADFETCH_BIT, RC_UVOLT_BIT};
  logic [8:0]          nmsk [5] = '{9'h001, 9'h100, 9'h100, 9'h010, 9'h004};
  logic [7:0]          ncfg [5] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h10};

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ==========================================
  // design and pin partner
  rcs_seq #(.LONG_HOLD(LH), .STOP_LONG(SL)) u_rcs_seq (
    .ref_clk, .rst_n, .power_on_pulse(1'b0), .undervolt_det(ev[8]),
    .rst_pin_i, .rst_pin_o, .rst_pin_oe, .watchdog_ovf(ev[0]),
    .cpu_bad_opcode(ev[1]), .cpu_stop_exec(ev[2]), .cpu_opcode_fetch(ev[3]),
    .addr_unmapped(ev[4]), .stop_req(ev[5]), .wait_req(ev[6]), .wake_req(ev[7]),
    .break_active, .monitor_mode, .pll_sel(1'b0), .pll_out_clock(1'b0),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .internal_reset,
    .cpu_clk_en, .periph_clk_en, .bus_tick, .reset_vector, .flag_clear_ok, .sys_count
  );
  rcs_pin_model u_rcs_pin_model (.rst_pin_o, .rst_pin_oe, .pull_low, .rst_pin_i);

  // ==========================================
  // tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask

  task automatic pulse(input logic [8:0] m, input int k);
    @(posedge ref_clk);
    ev <= m;
    repeat (k) @(posedge ref_clk);
    ev <= 9'h000;
  endtask

  // counts pin-drive and tail cycles; a stuck sequence ends the run
  task automatic seq(input bit drv);
    n = 0;
    p = 0;
    t = 0;
    ck = 2'b00;
    @(negedge ref_clk);
    while (drv && rst_pin_oe !== 1'b1 && n < 50) @(negedge ref_clk) n++;
    while (rst_pin_oe === 1'b1 && p < 5000)
    begin
      @(negedge ref_clk) p++;
      ck |= {cpu_clk_en, periph_clk_en};
    end
    vec = reset_vector;
    while (internal_reset === 1'b1 && t < 5000) @(negedge ref_clk) t++;
    if (n >= 50 || p >= 5000 || t >= 5000)
    begin
      err_count++;
      final_report();
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================
  // scenarios
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    seq(1'b0);
    chk(16'(p), 16'(LH + 32));
    chk(16'(p + t), 16'(LH + 64));
    chk(16'(ck), 16'h0000);
    chk(16'({cpu_clk_en, periph_clk_en}), 16'h0003);
    rd(ADDR_RESET_CAUSE);
    chk(16'(v), 16'h0080);
    wr(ADDR_RESET_CAUSE, 8'hff);
    rd(ADDR_RESET_CAUSE);
    chk(16'(v), 16'h0080);
    rd(16'hfe02);
    chk(16'(v), 16'h0000);
    n = 0;
    repeat (40) @(negedge ref_clk) n += int'(bus_tick);
    chk(16'(n), 16'h000a);
    $display("test power_on done");
    wr(ADDR_BREAK_FLAG, 8'h80);
    rd(ADDR_BREAK_FLAG);
    chk(16'(v), 16'h0080);
    @(posedge ref_clk) break_active <= 1'b1;
    @(negedge ref_clk);
    chk(16'(flag_clear_ok), 16'h0001);
    wr(ADDR_BREAK_FLAG, 8'h00);
    @(negedge ref_clk);
    chk(16'(flag_clear_ok), 16'h0000);
    @(posedge ref_clk) break_active <= 1'b0;
    $display("test break done");
    pulse(9'h040, 1);
    repeat (3) @(negedge ref_clk);
    chk(16'({cpu_clk_en, periph_clk_en}), 16'h0001);
    pulse(9'h080, 1);
    repeat (3) @(negedge ref_clk);
    chk(16'({cpu_clk_en, periph_clk_en}), 16'h0003);
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_CONFIG, (i == 0) ? 8'h18 : 8'h10);
      pulse(9'h020, 1);
      repeat (3) @(negedge ref_clk);
      chk(16'({cpu_clk_en, periph_clk_en}), 16'h0000);
      pulse(9'h080, 1);
      n = 0;
      while (periph_clk_en !== 1'b1 && n < 200) @(negedge ref_clk) n++;
      c0 = (i == 0) ? 32 : SL;
      chk(16'(n >= c0 - 2 && n <= c0 + 4), 16'h0001);
      if (n >= 200)
        final_report();
    end
    $display("test wait_stop done");
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_CONFIG, ncfg[i]);
      pulse(nmsk[i], 3);
      repeat (20) @(negedge ref_clk);
      chk(16'(rst_pin_oe | internal_reset), 16'h0000);
    end
    $display("test refused done");
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_BREAK_FLAG, 8'h80);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge ref_clk) monitor_mode <= (i >= 3);
      // the synchronised watchdog must not restart the drive window
      pulse(rmsk[i], (i == 0) ? 1 : 3);
      seq(1'b1);
      c0 = (i == 4) ? LH + 32 : 32;
      chk(16'(p >= c0 && p <= c0 + ((i == 4) ? 4 : 0)), 16'h0001);
      chk(16'(t), 16'h0020);
      chk(16'(ck), 16'h0000);
      chk(vec, (i >= 3) ? VEC_MONITOR : VEC_USER);
      chk(16'(int'(sys_count) <= c0 + 40), 16'h0001);
      rd(ADDR_RESET_CAUSE);
      chk(16'({v[rbit[i]], v[2], v[0]}), 16'h0004);
      rd(ADDR_BREAK_FLAG);
      chk(16'(v), 16'h0000);
    end
    $display("test internal done");
    @(posedge ref_clk) monitor_mode <= 1'b0;
    @(negedge ref_clk);
    sc0 = sys_count;
    c0 = cyc;
    @(posedge ref_clk) pull_low <= 1'b1;
    repeat (20) @(negedge ref_clk);
    chk(16'(internal_reset), 16'h0001);
    @(posedge ref_clk) pull_low <= 1'b0;
    seq(1'b0);
    chk(16'(t >= 32 && t <= 36), 16'h0001);
    chk(16'(sys_count), 16'(SYSCNT_W'(sc0 + (cyc - c0))));
    rd(ADDR_RESET_CAUSE);
    chk(16'(v[RC_PIN_BIT]), 16'h0001);
    $display("test pin done");
    final_report();
  end
endmodule // tb_rcs_seq
